// file: common/icw_defines.svh
// Constants of the indexed configuration block: port addresses, keys,
// configuration indices, logical device numbers, field bits and resets.
// Assumes the includer compiles it once per unit; the guard protects that.
`ifndef ICW_DEFINES_SVH
`define ICW_DEFINES_SVH

// Index port of each port pair; the data port sits one address above
`define ICW_PAIR0_INDEX 16'h002e
`define ICW_PAIR1_INDEX 16'h004e
`define ICW_PAIR_COUNT 2

// Entry key, written twice in a row, and exit key
`define ICW_ENTER_KEY 8'h87
`define ICW_EXIT_KEY 8'haa

// Configuration indices
`define ICW_IDX_DEVICE_SELECT 8'h07
`define ICW_IDX_DIGITAL_INPUT 8'hf1
`define ICW_IDX_DIGITAL_OUTPUT 8'hf2
`define ICW_IDX_WD_UNIT 8'hf5
`define ICW_IDX_WD_COUNT 8'hf6
`define ICW_IDX_WD_EVENT 8'hf7

// Logical device numbers
`define ICW_LDN_DIO 8'h07
`define ICW_LDN_WATCHDOG 8'h08

// Field positions
`define ICW_WD_UNIT_MINUTE_BIT 3
`define ICW_WD_EVENT_MOUSE_BIT 7
`define ICW_WD_EVENT_KBD_BIT 6

// Reset value and floating read value
`define ICW_RST_BYTE 8'h00
`define ICW_FLOAT_BYTE 8'hff

// Seconds per minute for the minute prescaler
`define ICW_SECONDS_PER_MINUTE 6'h3c

`endif

// file: common/icw_pkg.sv
// Types shared by the indexed configuration block.
// Assumes icw_defines.svh supplies the numeric constants.
package icw_pkg;

	// One host I/O cycle, as seen on the port bus
	typedef struct packed {
		logic wr; // Write strobe, one cycle
		logic rd; // Read strobe, one cycle
		logic [15:0] addr; // I/O port address
		logic [7:0] data; // Write data
	} icw_req_type;

	// Configuration entry state of one port pair
	typedef enum logic [1:0] {
		ICW_LOCKED,
		ICW_HALF_KEY,
		ICW_OPEN
	} icw_lock_type;

endpackage

// file: hdl/icw_config_dio_wd.sv
// Configuration register block with a watchdog and an 8-in/8-out
// digital I/O function, reached through two index/data port pairs.
// Assumes host I/O strobes, digital inputs and the one-second tick are
// synchronous to clk; the tick comes from a free-running source apart
// from the host oscillator.
//
// Behaviour
// - Watchdog counts an independent time source
// - Expiry drives a system reset output
// - Timeout count ranges one to 255 units
// - Index f5 bit 3 picks minutes
// - Writing index f6 loads remaining units
// - Rewriting count refreshes it, preventing reset
// - Index f7 holds mouse, keyboard event enables
// - Two 0x87 index writes open access
// - Index port then data port, two pairs
// - Index 07 selects the logical device
// - Watchdog registers only under device 08
// - Index f1 under device 07 reads inputs
// - Index f2 write drives the output lines
// - First pair maps lines 3..0 in byte
// - Second pair maps lines 7..4 likewise
`timescale 1ns/1ps
`include "icw_defines.svh"

module icw_config_dio_wd (
	input wire logic clk, // 250 MHz system clock
	input wire logic sys_rst, // Synchronous reset, active high
	input wire icw_pkg::icw_req_type host_req, // Host I/O cycle
	output logic [7:0] host_rdata, // Read data, one cycle after rd
	output logic host_rvalid, // Read data valid pulse
	input wire logic [7:0] digital_in, // Input lines 7..0
	output logic [7:0] digital_out, // Output lines 7..0
	input wire logic second_tick, // One pulse per second, free source
	input wire logic mouse_activity, // Mouse activity pulse
	input wire logic kbd_activity, // Keyboard activity pulse
	output logic system_reset // One-cycle watchdog reset pulse
);

	// Per-pair configuration state
	icw_pkg::icw_lock_type lock_state [`ICW_PAIR_COUNT]; // Entry state
	logic [7:0] index_reg [`ICW_PAIR_COUNT]; // Selected index
	logic [7:0] device_sel [`ICW_PAIR_COUNT]; // Selected logical device
	logic [1:0] hit_index; // Access at an index port
	logic [1:0] hit_data; // Access at a data port
	logic [1:0] data_write; // Open data-port write per pair

	// Shared registers
	logic [7:0] watchdog_unit_control; // Unit select and spare bits
	logic [7:0] watchdog_timeout_count; // Remaining units, live
	logic [7:0] watchdog_event_enable; // Activity sources that refresh
	logic [7:0] reload_count; // Last written timeout, for refresh
	logic [5:0] minute_prescale; // Seconds into the current minute
	logic unit_tick; // One pulse per counting unit

	// Merged writes, first pair taking priority on a same-cycle clash
	logic wr_out_en;
	logic [7:0] next_digital_out;
	logic wr_unit_en;
	logic wr_count_en;
	logic wr_event_en;
	logic [7:0] wr_byte;

	// Packs the I/O byte of one pair: in hi two, four outputs, in lo two
	function automatic logic [7:0] pack_dio(input logic [7:0] din,
		input logic [7:0] dout, input int p);
		logic [3:0] i4;
		logic [3:0] o4;
		i4 = din[4*p +: 4];
		o4 = dout[4*p +: 4];
		pack_dio = {i4[3], i4[2], o4, i4[1], i4[0]};
	endfunction

	// Per-pair address decode, entry sequence and pointers
	genvar gp;
	generate
		for (gp = 0; gp < `ICW_PAIR_COUNT; gp++) begin : g_pair
			localparam logic [15:0] BASE = (gp == 0) ?
				`ICW_PAIR0_INDEX : `ICW_PAIR1_INDEX;

			// Index port is the lower address, data port the next one
			assign hit_index[gp] = host_req.addr == BASE;
			assign hit_data[gp] = host_req.addr == BASE + 16'h0001;
			assign data_write[gp] = host_req.wr & hit_data[gp] &
				(lock_state[gp] == icw_pkg::ICW_OPEN);

			// Entry key must land twice back to back at the index port;
			// any other index write before the second key starts over
			always_ff @(posedge clk) begin
				if (sys_rst) begin
					lock_state[gp] <= icw_pkg::ICW_LOCKED;
				end else if (host_req.wr && hit_index[gp]) begin
					case (lock_state[gp])
						icw_pkg::ICW_LOCKED: begin
							if (host_req.data == `ICW_ENTER_KEY) begin
								lock_state[gp] <= icw_pkg::ICW_HALF_KEY;
							end
						end
						icw_pkg::ICW_HALF_KEY: begin
							// Second key opens, anything else relocks
							if (host_req.data == `ICW_ENTER_KEY) begin
								lock_state[gp] <= icw_pkg::ICW_OPEN;
							end else begin
								lock_state[gp] <= icw_pkg::ICW_LOCKED;
							end
						end
						icw_pkg::ICW_OPEN: begin
							if (host_req.data == `ICW_EXIT_KEY) begin
								lock_state[gp] <= icw_pkg::ICW_LOCKED;
							end
						end
						default: begin
							lock_state[gp] <= icw_pkg::ICW_LOCKED;
						end
					endcase
				end
			end

			// Index pointer follows index-port writes once open
			always_ff @(posedge clk) begin
				if (sys_rst) begin
					index_reg[gp] <= `ICW_RST_BYTE;
				end else if (host_req.wr && hit_index[gp] &&
					lock_state[gp] == icw_pkg::ICW_OPEN &&
					host_req.data != `ICW_EXIT_KEY) begin
					index_reg[gp] <= host_req.data;
				end
			end

			// Logical device selector behind index 07
			always_ff @(posedge clk) begin
				if (sys_rst) begin
					device_sel[gp] <= `ICW_RST_BYTE;
				end else if (data_write[gp] &&
					index_reg[gp] == `ICW_IDX_DEVICE_SELECT) begin
					device_sel[gp] <= host_req.data;
				end
			end
		end
	endgenerate

	// Merge data-port writes of both pairs into shared register strobes
	always_comb begin
		wr_out_en = 1'b0;
		next_digital_out = digital_out;
		wr_unit_en = 1'b0;
		wr_count_en = 1'b0;
		wr_event_en = 1'b0;
		wr_byte = host_req.data;
		// Highest index first so pair 0 wins a clash
		for (int p = `ICW_PAIR_COUNT - 1; p >= 0; p--) begin
			if (data_write[p]) begin
				wr_out_en = 1'b0;
				wr_unit_en = 1'b0;
				wr_count_en = 1'b0;
				wr_event_en = 1'b0;
				if (device_sel[p] == `ICW_LDN_DIO &&
					index_reg[p] == `ICW_IDX_DIGITAL_OUTPUT) begin
					// Only the output field of the byte lands
					wr_out_en = 1'b1;
					next_digital_out = digital_out;
					next_digital_out[4*p +: 4] = host_req.data[5:2];
				end
				if (device_sel[p] == `ICW_LDN_WATCHDOG) begin
					wr_unit_en = index_reg[p] == `ICW_IDX_WD_UNIT;
					wr_count_en = index_reg[p] == `ICW_IDX_WD_COUNT;
					wr_event_en = index_reg[p] == `ICW_IDX_WD_EVENT;
				end
			end
		end
	end

	// Digital output lines
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			digital_out <= `ICW_RST_BYTE;
		end else if (wr_out_en) begin
			digital_out <= next_digital_out;
		end
	end

	// Watchdog unit and event-enable registers
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			watchdog_unit_control <= `ICW_RST_BYTE;
			watchdog_event_enable <= `ICW_RST_BYTE;
		end else begin
			if (wr_unit_en) begin
				watchdog_unit_control <= wr_byte;
			end
			if (wr_event_en) begin
				// Zero here disables every activity source
				watchdog_event_enable <= wr_byte;
			end
		end
	end

	// Unit tick: seconds pass straight, minutes divide by sixty; the
	// host clock only samples the tick, the timing comes from its source
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			minute_prescale <= 6'h00;
		end else if (second_tick) begin
			if (minute_prescale == `ICW_SECONDS_PER_MINUTE - 6'h01) begin
				minute_prescale <= 6'h00;
			end else begin
				minute_prescale <= minute_prescale + 6'h01;
			end
		end
	end
	assign unit_tick = second_tick &
		(!watchdog_unit_control[`ICW_WD_UNIT_MINUTE_BIT] ||
		minute_prescale == `ICW_SECONDS_PER_MINUTE - 6'h01);

	// Remaining count: a write loads, enabled activity refreshes from the
	// last written value, each unit tick steps down while nonzero
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			watchdog_timeout_count <= `ICW_RST_BYTE;
			reload_count <= `ICW_RST_BYTE;
		end else if (wr_count_en) begin
			// A rewrite beats a tick in the same cycle
			watchdog_timeout_count <= wr_byte;
			reload_count <= wr_byte;
		end else if ((mouse_activity &&
			watchdog_event_enable[`ICW_WD_EVENT_MOUSE_BIT]) ||
			(kbd_activity &&
			watchdog_event_enable[`ICW_WD_EVENT_KBD_BIT])) begin
			if (watchdog_timeout_count != 8'h00) begin
				watchdog_timeout_count <= reload_count;
			end
		end else if (unit_tick && watchdog_timeout_count != 8'h00) begin
			watchdog_timeout_count <= watchdog_timeout_count - 8'h01;
		end
	end

	// One reset pulse when the count steps from one to zero; zero idles
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			system_reset <= 1'b0;
		end else begin
			system_reset <= unit_tick && !wr_count_en &&
				watchdog_timeout_count == 8'h01 &&
				!((mouse_activity &&
				watchdog_event_enable[`ICW_WD_EVENT_MOUSE_BIT]) ||
				(kbd_activity &&
				watchdog_event_enable[`ICW_WD_EVENT_KBD_BIT]));
		end
	end

	// Read path; unclaimed or locked ports float high like an idle bus
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			host_rdata <= `ICW_RST_BYTE;
			host_rvalid <= 1'b0;
		end else begin
			host_rvalid <= host_req.rd;
			host_rdata <= `ICW_FLOAT_BYTE;
			if (host_req.rd) begin
				for (int p = `ICW_PAIR_COUNT - 1; p >= 0; p--) begin
					if (lock_state[p] == icw_pkg::ICW_OPEN) begin
						if (hit_index[p]) begin
							host_rdata <= index_reg[p];
						end else if (hit_data[p]) begin
							host_rdata <= `ICW_RST_BYTE;
							if (index_reg[p] == `ICW_IDX_DEVICE_SELECT) begin
								host_rdata <= device_sel[p];
							end else if (device_sel[p] == `ICW_LDN_DIO) begin
								if (index_reg[p] == `ICW_IDX_DIGITAL_INPUT ||
									index_reg[p] == `ICW_IDX_DIGITAL_OUTPUT) begin
									host_rdata <= pack_dio(digital_in,
										digital_out, p);
								end
							end else if (device_sel[p] == `ICW_LDN_WATCHDOG) begin
								// Watchdog set hidden under other devices
								case (index_reg[p])
									`ICW_IDX_WD_UNIT: begin
										host_rdata <= watchdog_unit_control;
									end
									`ICW_IDX_WD_COUNT: begin
										host_rdata <= watchdog_timeout_count;
									end
									`ICW_IDX_WD_EVENT: begin
										host_rdata <= watchdog_event_enable;
									end
									default: begin
										host_rdata <= `ICW_RST_BYTE;
									end
								endcase
							end
						end
					end
				end
			end
		end
	end

endmodule

// file: bench/icw_config_dio_wd_assertions.sv
// Checker of the configuration block: bus answers, output lines, reset.
// Assumes it is bound to the block and sees only the block's ports.
`timescale 1ns/1ps
module icw_config_dio_wd_assertions (
	input wire logic clk, // Clock
	input wire logic sys_rst, // Reset
	input wire icw_pkg::icw_req_type host_req, // Host cycle
	input wire logic [7:0] host_rdata, // Read data
	input wire logic host_rvalid, // Read valid
	input wire logic [7:0] digital_in, // Input lines
	input wire logic [7:0] digital_out, // Output lines
	input wire logic second_tick, // Second pulse
	input wire logic mouse_activity, // Mouse pulse
	input wire logic kbd_activity, // Keyboard pulse
	input wire logic system_reset // Watchdog reset
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	// Only the four pair ports decode; anything else must float high
	wire mapped = host_req.addr inside {16'h002e, 16'h002f, 16'h004e,
		16'h004f};
	property p_rd_answer; host_req.rd |=> host_rvalid; endproperty
	a_rd_answer: assert property (p_rd_answer)
		else $error("read not answered");
	property p_rv_cause; host_rvalid |-> $past(host_req.rd); endproperty
	a_rv_cause: assert property (p_rv_cause)
		else $error("read valid without read");
	property p_unmapped; host_req.rd && !mapped |=> host_rdata == 8'hff;
	endproperty
	a_unmapped: assert property (p_unmapped)
		else $error("unmapped read not floating");
	property p_pulse; system_reset |=> !system_reset; endproperty
	a_pulse: assert property (p_pulse)
		else $error("reset pulse too long");
	// The pulse must follow a tick of the free source, never host traffic
	property p_tick_cause; system_reset |-> $past(second_tick); endproperty
	a_tick_cause: assert property (p_tick_cause)
		else $error("reset without tick");
	property p_out_cause;
		$changed(digital_out) |-> $past(host_req.wr && host_req.addr[0]);
	endproperty
	a_out_cause: assert property (p_out_cause)
		else $error("outputs moved without data write");
	property p_low_pair;
		$changed(digital_out[3:0]) |-> $past(host_req.addr == 16'h002f);
	endproperty
	a_low_pair: assert property (p_low_pair)
		else $error("low outputs moved by wrong port");
	property p_high_pair;
		$changed(digital_out[7:4]) |-> $past(host_req.addr == 16'h004f);
	endproperty
	a_high_pair: assert property (p_high_pair)
		else $error("high outputs moved by wrong port");
	c_read: cover property (host_rvalid);
	c_reset: cover property (system_reset);
	c_out: cover property ($changed(digital_out));
endmodule
bind icw_config_dio_wd icw_config_dio_wd_assertions
	i_icw_config_dio_wd_assertions (.clk(clk), .sys_rst(sys_rst),
	.host_req(host_req), .host_rdata(host_rdata), .host_rvalid(host_rvalid),
	.digital_in(digital_in), .digital_out(digital_out),
	.second_tick(second_tick), .mouse_activity(mouse_activity),
	.kbd_activity(kbd_activity), .system_reset(system_reset));

// file: bench/icw_host_model.sv
// Host processor model: port writes and reads, one cycle each.
// Assumes callers stand at a falling edge of clk.
`timescale 1ns/1ps
module icw_host_model (
	input wire logic clk, // System clock
	output icw_pkg::icw_req_type host_req, // Host cycle
	input wire logic [7:0] host_rdata, // Read data
	input wire logic host_rvalid // Read valid
);
	initial host_req = '{1'b0, 1'b0, 16'hffff, 8'hff};
	// One strobe cycle, then an idle cycle; released lines show the
	// inverse so a stale address can never pass for a held one
	task automatic io(input logic w, input logic [15:0] a,
		input logic [7:0] d, output logic [7:0] v);
		host_req = '{w, ~w, a, d};
		@(negedge clk);
		v = (host_rvalid === 1'b1) ? host_rdata : 8'hxx;
		host_req = '{1'b0, 1'b0, ~a, ~d};
		@(negedge clk);
	endtask
	// Index to the lower port, then data through the next one
	task automatic cfg(input logic w, input logic [15:0] p,
		input logic [7:0] r, input logic [7:0] d, output logic [7:0] v);
		io(1'b1, p, r, v);
		io(w, p + 16'h0001, d, v);
	endtask
	// Key twice in a row on the index port
	task automatic unlock(input logic [15:0] p);
		logic [7:0] v;
		io(1'b1, p, 8'h87, v);
		io(1'b1, p, 8'h87, v);
	endtask
endmodule

// file: bench/tb_icw_config_dio_wd.sv
// Testbench of the configuration block: locking, DIO maps, watchdog.
// Assumes the host model makes every port cycle at the falling edge.
`timescale 1ns/1ps
module tb_icw_config_dio_wd;
	logic clk = 1'b0; // System clock
	logic sys_rst = 1'b1; // Reset, held at start
	logic [7:0] din = 8'ha5; // Input line levels
	logic tick = 1'b0; // One-second pulse
	logic mouse = 1'b0; // Mouse activity
	logic kbd = 1'b0; // Keyboard activity
	icw_pkg::icw_req_type host_req; // Host cycle
	logic [7:0] host_rdata; // Read data
	logic host_rvalid; // Read valid
	logic [7:0] dout; // Output lines
	logic wd_rst; // Watchdog reset pulse
	logic [7:0] v; // Scratch read value
	int n_fail = 0; // Mismatches
	int checks_done = 0; // Comparisons
	int n_rst = 0; // Reset pulses seen
	int i; // Loop index
	initial forever #2 clk = ~clk;
	// Count pulses, so a double pulse shows up as a wrong total
	always @(posedge clk) if (wd_rst === 1'b1) n_rst++;
	icw_config_dio_wd i_icw_config_dio_wd (.clk(clk), .sys_rst(sys_rst),
		.host_req(host_req), .host_rdata(host_rdata),
		.host_rvalid(host_rvalid), .digital_in(din), .digital_out(dout),
		.second_tick(tick), .mouse_activity(mouse), .kbd_activity(kbd),
		.system_reset(wd_rst));
	icw_host_model i_icw_host_model (.clk(clk), .host_req(host_req),
		.host_rdata(host_rdata), .host_rvalid(host_rvalid));
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_fail++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [15:0] p, input logic [7:0] r,
		input logic [7:0] d);
		i_icw_host_model.cfg(1'b1, p, r, d, v);
	endtask
	task automatic rd(input logic [15:0] p, input logic [7:0] r,
		input logic [7:0] exp);
		i_icw_host_model.cfg(1'b0, p, r, 8'h00, v);
		chk(v, exp);
	endtask
	// Byte of one pair: two inputs, four outputs, two inputs
	function automatic logic [7:0] pk(input logic [7:0] d,
		input logic [7:0] o, input logic hi);
		return hi ? {d[7:6], o[7:4], d[5:4]} : {d[3:2], o[3:0], d[1:0]};
	endfunction
	task automatic ticks(input int n);
		repeat (n) begin
			tick = 1'b1;
			@(negedge clk);
			tick = 1'b0;
			@(negedge clk);
		end
	endtask
	task automatic finish_test();
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// Guard against a hang anywhere in the sequence
	initial begin
		#400000;
		n_fail++;
		finish_test();
	end
	initial begin
		repeat (5) @(negedge clk);
		sys_rst = 1'b0;
		@(negedge clk);
		rd(16'h002e, 8'hf1, 8'hff);
		rd(16'h0030, 8'h00, 8'hff);
		i_icw_host_model.unlock(16'h002e);
		wr(16'h002e, 8'h07, 8'h07);
		wr(16'h002e, 8'hf2, 8'h3c);
		chk(dout, 8'h0f);
		rd(16'h002e, 8'hf1, pk(din, 8'h0f, 1'b0));
		i_icw_host_model.unlock(16'h004e);
		wr(16'h004e, 8'h07, 8'h07);
		wr(16'h004e, 8'hf2, 8'h28);
		chk(dout, 8'haf);
		din = 8'h5a;
		rd(16'h004e, 8'hf2, pk(din, 8'haf, 1'b1));
		$display("test dio done");
		// Count written under the wrong device must not arm anything
		wr(16'h002e, 8'hf6, 8'h01);
		ticks(2);
		chk(n_rst[7:0], 8'h00);
		wr(16'h002e, 8'h07, 8'h08);
		wr(16'h002e, 8'hf5, 8'h00);
		wr(16'h002e, 8'hf7, 8'h00);
		wr(16'h002e, 8'hf6, 8'h03);
		ticks(2);
		chk(n_rst[7:0], 8'h00);
		ticks(1);
		chk(n_rst[7:0], 8'h01);
		ticks(2);
		chk(n_rst[7:0], 8'h01);
		wr(16'h002e, 8'hf6, 8'h02);
		ticks(1);
		wr(16'h002e, 8'hf6, 8'h02);
		ticks(1);
		chk(n_rst[7:0], 8'h01);
		ticks(1);
		chk(n_rst[7:0], 8'h02);
		// Mouse then keyboard activity, each behind its own enable
		for (i = 0; i < 2; i++) begin
			wr(16'h002e, 8'hf7, 8'h80 >> i);
			rd(16'h002e, 8'hf7, 8'h80 >> i);
			wr(16'h002e, 8'hf6, 8'h02);
			ticks(1);
			mouse = (i == 0);
			kbd = (i == 1);
			@(negedge clk);
			mouse = 1'b0;
			kbd = 1'b0;
			ticks(1);
			chk(n_rst[7:0], 8'(2 + i));
			ticks(1);
			chk(n_rst[7:0], 8'(3 + i));
		end
		// Sixty ticks hold exactly one minute boundary, whatever the phase
		wr(16'h002e, 8'hf5, 8'h08);
		wr(16'h002e, 8'hf6, 8'h02);
		ticks(60);
		chk(n_rst[7:0], 8'h04);
		ticks(60);
		chk(n_rst[7:0], 8'h05);
		$display("test watchdog done");
		i_icw_host_model.io(1'b1, 16'h002e, 8'haa, v);
		rd(16'h002e, 8'hf5, 8'hff);
		// Lock the second pair first, then a split key must not reopen it
		i_icw_host_model.io(1'b1, 16'h004e, 8'haa, v);
		i_icw_host_model.io(1'b1, 16'h004e, 8'h87, v);
		i_icw_host_model.io(1'b1, 16'h004e, 8'h07, v);
		i_icw_host_model.io(1'b1, 16'h004e, 8'h87, v);
		rd(16'h004e, 8'hf2, 8'hff);
		$display("test lock done");
		finish_test();
	end
endmodule
